// [rtl/servo_query_pkg.sv]
package servo_query_pkg;

    // ================================================================
    // Framing characters
    localparam logic [7:0] CH_BANG  = 8'h21;
    localparam logic [7:0] CH_HASH  = 8'h23;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_QMARK = 8'h3F;
    localparam logic [7:0] CH_DRV_A = 8'h41;
    localparam logic [7:0] CH_DRV_D = 8'h44;

    // ================================================================
    // Command codes, two ASCII letters
    localparam logic [15:0] CMD_MOTOR_WARN = 16'h4557;
    localparam logic [15:0] CMD_FLAGS      = 16'h4558;
    localparam logic [15:0] CMD_MAX_ACCEL  = 16'h4741;
    localparam logic [15:0] CMD_MAX_CURR   = 16'h4743;
    localparam logic [15:0] CMD_DEMAND_POS = 16'h4744;
    localparam logic [15:0] CMD_GLOB_ERR   = 16'h4745;
    localparam logic [15:0] CMD_ACTUAL_POS = 16'h4750;
    localparam logic [15:0] CMD_STATE_LET  = 16'h4753;
    localparam logic [15:0] CMD_MAX_SPEED  = 16'h4756;
    localparam logic [15:0] CMD_GLOB_WARN  = 16'h4757;

    // State letters
    localparam logic [7:0] LET_RUN  = 8'h52;
    localparam logic [7:0] LET_INIT = 8'h49;
    localparam logic [7:0] LET_DIS  = 8'h44;
    localparam logic [7:0] LET_ERR  = 8'h45;

    // ================================================================
    // Register map and fields
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ  = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CNT  = 8'h10;
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CLR_BIT  = 1;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_BAD_BIT   = 1;
    localparam int IRQ_FAULT_BIT = 2;
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [2:0] MASK_RST    = 3'h0;
    localparam logic [15:0] WARN_KEEP  = 16'h014E;
    localparam logic [7:0] FAULT_CODE  = 8'h20;  // Arbitrary value

    // ================================================================
    // Timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int WARN_HOLD_S   = 5;
    localparam int WARN_HOLD_CYC = WARN_HOLD_S * CLK_HZ;

    // ================================================================
    // Types
    typedef enum logic [1:0] {
        CS_INIT = 2'b00,
        CS_DIS  = 2'b01,
        CS_RUN  = 2'b10,
        CS_ERR  = 2'b11
    } ctl_state_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_C1   = 4'b0001,
        S_C2   = 4'b0010,
        S_PAR  = 4'b0011,
        S_HASH = 4'b0100,
        S_LET  = 4'b0101,
        S_SIGN = 4'b0110,
        S_DIG  = 4'b0111,
        S_CR   = 4'b1000
    } fsm_t;

    typedef struct packed {
        logic [8:0]  warn;
        logic [15:0] accel;
        logic [15:0] current;
        logic [15:0] demand;
        logic [15:0] actual;
        logic [15:0] speed;
    } motor_t;

    typedef struct packed {
        ctl_state_t  state;
        logic        emerg;
        logic        init_not_done;
        logic        err_present;
        logic [3:0]  in_pos;
        logic [7:0]  err_code;
        logic [15:0] glob_err;
        logic        ctrl_warn;
        logic [3:0]  link_voltage;
    } ctrl_in_t;

    typedef struct packed {
        fsm_t        st;
        logic [7:0]  cmd0;
        logic [7:0]  cmd1;
        logic [1:0]  drive;
        logic        drive_ok;
        logic [7:0]  letter;
        logic        has_let;
        logic        has_num;
        logic        neg;
        logic [15:0] mag;
        logic [2:0]  idx;
        logic [3:0]  dig;
        logic        seen;
        logic [7:0]  tx_data;
        logic        tx_valid;
        logic        fault;
        logic [26:0] fault_cnt;
        logic        ctrl_en;
        logic [2:0]  irq;
        logic [2:0]  mask;
        logic [15:0] cmd_cnt;
        logic [31:0] prdata;
    } state_t;

endpackage

// [rtl/servo_query.sv]
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module servo_query #(
    parameter int WARN_HOLD = servo_query_pkg::WARN_HOLD_CYC
) (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          irq,
    // Host byte link
    input  wire logic                     rx_valid,
    input  wire logic [7:0]               rx_data,
    output logic                          rx_ready,
    output logic                          tx_valid,
    output logic [7:0]                    tx_data,
    input  wire logic                     tx_ready,
    // Servo core status
    input  wire servo_query_pkg::motor_t  motor [4],
    input  wire servo_query_pkg::ctrl_in_t ctl
);

    servo_query_pkg::state_t q;
    servo_query_pkg::state_t n;
    servo_query_pkg::motor_t m;
    logic                    rx_fire;
    logic                    decode;
    logic                    err_now;
    logic                    hit;
    logic                    acc_wr;
    // ================================================================
    // Handshakes
    assign m       = motor[q.drive];
    assign rx_ready = q.ctrl_en && (q.st inside {servo_query_pkg::S_IDLE,
                      servo_query_pkg::S_C1, servo_query_pkg::S_C2,
                      servo_query_pkg::S_PAR});
    assign rx_fire = rx_valid && rx_ready;
    assign decode  = rx_fire && q.st == servo_query_pkg::S_PAR &&
                     rx_data == servo_query_pkg::CH_CR;
    assign err_now = q.fault || ctl.state == servo_query_pkg::CS_ERR;
    assign hit     = paddr inside {servo_query_pkg::ADDR_CTRL,
                     servo_query_pkg::ADDR_STAT, servo_query_pkg::ADDR_IRQ,
                     servo_query_pkg::ADDR_MASK, servo_query_pkg::ADDR_CNT};
    assign acc_wr  = psel && penable && pwrite && hit;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata  = q.prdata;
    assign irq     = |(q.irq & q.mask);
    assign tx_valid = q.tx_valid;
    assign tx_data  = q.tx_data;
    function automatic logic [15:0] pow10(input logic [2:0] i);
        case (i)
            3'h4:    pow10 = 16'h2710;
            3'h3:    pow10 = 16'h03E8;
            3'h2:    pow10 = 16'h0064;
            3'h1:    pow10 = 16'h000A;
            default: pow10 = 16'h0001;
        endcase
    endfunction
    // ================================================================
    // Next state
    always_comb begin
        logic [15:0] v;
        logic        per;
        logic        sgn;
        logic        bad;
        logic [2:0]  ev;
        logic [2:0]  w1c;
        logic        run_b;
        v   = 16'h0000;
        per = 1'b1;
        sgn = 1'b0;
        bad = 1'b0;
        ev  = 3'h0;
        w1c = 3'h0;
        run_b = !err_now && ctl.state == servo_query_pkg::CS_RUN;
        n = q;
        // Warning hold timer; a warning held for WARN_HOLD cycles trips the fault
        if (ctl.ctrl_warn) begin
            if (q.fault_cnt >= 27'(WARN_HOLD - 1)) begin
                n.fault = 1'b1;
                ev[servo_query_pkg::IRQ_FAULT_BIT] = !q.fault;
            end else begin
                n.fault_cnt = q.fault_cnt + 27'h1;
            end
        end else begin
            n.fault_cnt = 27'h0;
        end
        // Register access; read data captured in setup phase
        if (psel && !penable) begin
            case (paddr)
                servo_query_pkg::ADDR_CTRL: n.prdata = {31'h0, q.ctrl_en};
                servo_query_pkg::ADDR_STAT:
                    n.prdata = {29'h0, err_now, q.fault,
                                q.st != servo_query_pkg::S_IDLE};
                servo_query_pkg::ADDR_IRQ:  n.prdata = {29'h0, q.irq};
                servo_query_pkg::ADDR_MASK: n.prdata = {29'h0, q.mask};
                servo_query_pkg::ADDR_CNT:  n.prdata = {16'h0, q.cmd_cnt};
                default:                    n.prdata = 32'h0;
            endcase
        end
        if (acc_wr) begin
            case (paddr)
                servo_query_pkg::ADDR_CTRL: begin
                    n.ctrl_en = pwdata[servo_query_pkg::CTRL_EN_BIT];
                    if (pwdata[servo_query_pkg::CTRL_CLR_BIT] &&
                        !(ctl.ctrl_warn && q.fault_cnt >= 27'(WARN_HOLD - 1))) begin
                        n.fault = 1'b0;
                        n.fault_cnt = 27'h0;
                    end
                end
                servo_query_pkg::ADDR_IRQ:  w1c = pwdata[2:0];
                servo_query_pkg::ADDR_MASK: n.mask = pwdata[2:0];
                default: ;
            endcase
        end
        // Command decode at the closing CR
        case ({q.cmd0, q.cmd1})
            servo_query_pkg::CMD_MOTOR_WARN:
                v = {7'h0, m.warn} & servo_query_pkg::WARN_KEEP;
            servo_query_pkg::CMD_FLAGS: begin
                per = 1'b0;
                v = {4'h0, ctl.emerg,
                     !err_now && ctl.state == servo_query_pkg::CS_INIT,
                     !err_now && ctl.state == servo_query_pkg::CS_DIS,
                     err_now, run_b, 7'h0};
                v[6:0] = {ctl.init_not_done,
                          ctl.ctrl_warn || |ctl.link_voltage,
                          ctl.err_present || err_now, ctl.in_pos};
            end
            servo_query_pkg::CMD_MAX_ACCEL:  v = m.accel;
            servo_query_pkg::CMD_MAX_CURR:   v = m.current;
            servo_query_pkg::CMD_DEMAND_POS: begin
                v = m.demand;
                sgn = 1'b1;
            end
            servo_query_pkg::CMD_GLOB_ERR: begin
                per = 1'b0;
                v = ctl.glob_err;
            end
            servo_query_pkg::CMD_ACTUAL_POS: begin
                v = m.actual;
                sgn = 1'b1;
            end
            servo_query_pkg::CMD_STATE_LET: begin
                per = 1'b0;
                v = {8'h0, q.fault ? servo_query_pkg::FAULT_CODE : ctl.err_code};
            end
            servo_query_pkg::CMD_MAX_SPEED: v = m.speed;
            servo_query_pkg::CMD_GLOB_WARN: begin
                per = 1'b0;
                v = {10'h0, ctl.ctrl_warn, ctl.link_voltage, 1'b0};
            end
            default: bad = 1'b1;
        endcase
        bad = bad || (per && !q.drive_ok);
        // Request parser and reply emitter
        case (q.st)
            servo_query_pkg::S_IDLE: begin
                if (rx_fire && rx_data == servo_query_pkg::CH_BANG) begin
                    n.st = servo_query_pkg::S_C1;
                end
            end
            servo_query_pkg::S_C1: begin
                if (rx_fire) begin
                    n.cmd0 = rx_data;
                    n.st = servo_query_pkg::S_C2;
                end
            end
            servo_query_pkg::S_C2: begin
                if (rx_fire) begin
                    n.cmd1 = rx_data;
                    n.drive_ok = 1'b0;
                    n.st = servo_query_pkg::S_PAR;
                end
            end
            servo_query_pkg::S_PAR: begin
                if (decode) begin
                    n.cmd_cnt = q.cmd_cnt + 16'h1;
                    n.has_let = bad || {q.cmd0, q.cmd1} == servo_query_pkg::CMD_STATE_LET;
                    n.has_num = !bad;
                    if (bad) begin
                        n.letter = servo_query_pkg::CH_QMARK;
                        ev[servo_query_pkg::IRQ_BAD_BIT] = 1'b1;
                    end else if (n.has_let) begin
                        n.has_num = err_now;
                        if (err_now) begin
                            n.letter = servo_query_pkg::LET_ERR;
                        end else if (ctl.state == servo_query_pkg::CS_RUN) begin
                            n.letter = servo_query_pkg::LET_RUN;
                        end else if (ctl.state == servo_query_pkg::CS_INIT) begin
                            n.letter = servo_query_pkg::LET_INIT;
                        end else begin
                            n.letter = servo_query_pkg::LET_DIS;
                        end
                    end
                    n.neg = sgn && v[15];
                    n.mag = n.neg ? 16'(-v) : v;
                    n.idx = 3'h4;
                    n.dig = 4'h0;
                    n.seen = 1'b0;
                    n.st = servo_query_pkg::S_HASH;
                end else if (rx_fire && rx_data == servo_query_pkg::CH_BANG) begin
                    n.st = servo_query_pkg::S_C1;
                end else if (rx_fire && rx_data >= servo_query_pkg::CH_DRV_A &&
                             rx_data <= servo_query_pkg::CH_DRV_D) begin
                    n.drive = 2'(rx_data - servo_query_pkg::CH_DRV_A);
                    n.drive_ok = 1'b1;
                end
            end
            servo_query_pkg::S_HASH: begin
                if (!q.tx_valid) begin
                    n.tx_data = servo_query_pkg::CH_HASH;
                    n.tx_valid = 1'b1;
                end else if (tx_ready) begin
                    n.tx_valid = 1'b0;
                    n.st = servo_query_pkg::S_LET;
                end
            end
            servo_query_pkg::S_LET: begin
                if (!q.has_let) begin
                    n.st = servo_query_pkg::S_SIGN;
                end else if (!q.tx_valid) begin
                    n.tx_data = q.letter;
                    n.tx_valid = 1'b1;
                end else if (tx_ready) begin
                    n.tx_valid = 1'b0;
                    n.st = servo_query_pkg::S_SIGN;
                end
            end
            servo_query_pkg::S_SIGN: begin
                if (!q.has_num) begin
                    n.st = servo_query_pkg::S_CR;
                end else if (!q.neg) begin
                    n.st = servo_query_pkg::S_DIG;
                end else if (!q.tx_valid) begin
                    n.tx_data = servo_query_pkg::CH_MINUS;
                    n.tx_valid = 1'b1;
                end else if (tx_ready) begin
                    n.tx_valid = 1'b0;
                    n.st = servo_query_pkg::S_DIG;
                end
            end
            servo_query_pkg::S_DIG: begin
                // Subtract powers of ten; slower but no divider
                if (!q.tx_valid) begin
                    if (q.mag >= pow10(q.idx)) begin
                        n.mag = q.mag - pow10(q.idx);
                        n.dig = q.dig + 4'h1;
                    end else if (q.dig != 4'h0 || q.seen || q.idx == 3'h0) begin
                        n.tx_data = servo_query_pkg::CH_ZERO + {4'h0, q.dig};
                        n.tx_valid = 1'b1;
                        n.seen = 1'b1;
                    end else begin
                        n.idx = q.idx - 3'h1;
                    end
                end else if (tx_ready) begin
                    n.tx_valid = 1'b0;
                    n.dig = 4'h0;
                    if (q.idx == 3'h0) begin
                        n.st = servo_query_pkg::S_CR;
                    end else begin
                        n.idx = q.idx - 3'h1;
                    end
                end
            end
            servo_query_pkg::S_CR: begin
                if (!q.tx_valid) begin
                    n.tx_data = servo_query_pkg::CH_CR;
                    n.tx_valid = 1'b1;
                end else if (tx_ready) begin
                    n.tx_valid = 1'b0;
                    ev[servo_query_pkg::IRQ_DONE_BIT] = 1'b1;
                    n.st = servo_query_pkg::S_IDLE;
                end
            end
            default: n.st = servo_query_pkg::S_IDLE;
        endcase
        // Set wins over write-one-to-clear
        n.irq = (q.irq & ~w1c) | ev;
    end
    // ================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl_en <= servo_query_pkg::CTRL_EN_RST;
            q.mask <= servo_query_pkg::MASK_RST;
        end else begin
            q <= n;
        end
    end
    // ================================================================
    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_frame;
        q.st == servo_query_pkg::S_HASH && q.tx_valid |-> tx_data == servo_query_pkg::CH_HASH;
    endproperty
    a_frame: assert property (p_frame) else $error("reply not opened by hash");
    property p_warn;
        decode && {q.cmd0, q.cmd1} == servo_query_pkg::CMD_MOTOR_WARN && q.drive_ok
            |=> (q.mag & ~servo_query_pkg::WARN_KEEP) == 16'h0;
    endproperty
    a_warn: assert property (p_warn) else $error("reserved warn bit set");
    property p_onehot;
        decode && {q.cmd0, q.cmd1} == servo_query_pkg::CMD_FLAGS |=> $onehot(q.mag[10:7]);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state bits not one-hot");
    property p_inpos;
        decode && {q.cmd0, q.cmd1} == servo_query_pkg::CMD_FLAGS
            |=> q.mag[3:0] == $past(ctl.in_pos);
    endproperty
    a_inpos: assert property (p_inpos) else $error("in-position bits wrong");
    property p_num;
        decode && {q.cmd0, q.cmd1} == servo_query_pkg::CMD_STATE_LET
            |=> q.has_let && q.has_num == $past(err_now);
    endproperty
    a_num: assert property (p_num) else $error("error number rule broken");
    property p_run;
        decode && {q.cmd0, q.cmd1} == servo_query_pkg::CMD_STATE_LET && !err_now &&
            ctl.state == servo_query_pkg::CS_RUN |=> q.letter == servo_query_pkg::LET_RUN;
    endproperty
    a_run: assert property (p_run) else $error("run letter wrong");
    property p_trip;
        ctl.ctrl_warn && q.fault_cnt >= 27'(WARN_HOLD - 1) |=> q.fault;
    endproperty
    a_trip: assert property (p_trip) else $error("warning did not trip fault");
    property p_hold;
        !ctl.ctrl_warn |=> q.fault_cnt == 27'h0 && $stable(q.fault) || $fell(q.fault);
    endproperty
    a_hold: assert property (p_hold) else $error("hold timer not reset");
    property p_gwarn;
        decode && {q.cmd0, q.cmd1} == servo_query_pkg::CMD_GLOB_WARN
            |=> q.mag[5] == $past(ctl.ctrl_warn) && q.mag[0] == 1'b0;
    endproperty
    a_gwarn: assert property (p_gwarn) else $error("controller warn bit wrong");
    property p_minus;
        q.st == servo_query_pkg::S_SIGN && q.tx_valid |-> q.neg && tx_data == servo_query_pkg::CH_MINUS;
    endproperty
    a_minus: assert property (p_minus) else $error("sign character wrong");
endmodule

// [testbench/host_model.sv]
`timescale 1ns/1ps
// ================================================================
// Host side of the byte link: sends framed requests, collects replies
module host_model (
    // Clock and reply pacing
    input  wire logic       pclk,
    input  wire logic       slow,
    // Request bytes
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    // Reply bytes
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [63:0] reply;
    logic        done;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end

    // Byte held until taken; idle data inverted so stale bytes never look valid
    task automatic send(input logic [39:0] f);
        for (int i = 4; i >= 0; i--) begin
            rx_valid <= 1'b1;
            rx_data  <= f[i*8 +: 8];
            @(posedge pclk iff rx_ready);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~f[7:0];
    endtask

    // Terminator ends the reply; slow mode stalls every other cycle
    always @(posedge pclk) begin
        // A new request clears the last reply
        if (rx_valid && rx_ready && rx_data == servo_query_pkg::CH_BANG) begin
            reply <= 64'h0;
            done  <= 1'b0;
        end
        if (tx_valid && tx_ready) begin
            if (tx_data === servo_query_pkg::CH_CR) begin
                done <= 1'b1;
            end else begin
                reply <= {reply[55:0], tx_data};
            end
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule

// [testbench/servo_query_tb.sv]
`timescale 1ns/1ps
module servo_query_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_valid, rx_ready, tx_valid, tx_ready, err, slow;
    logic [7:0] rx_data, tx_data;
    servo_query_pkg::motor_t   motor [4];
    servo_query_pkg::ctrl_in_t ctl;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    servo_query #(.WARN_HOLD(20)) servo_query_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .motor(motor), .ctl(ctl));
    host_model host_model_i (.pclk(pclk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    // ================================================================
    // Checking and closing
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ================================================================
    // APB master and query helpers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic query(input logic [15:0] c, input logic [7:0] p, input logic [63:0] exp);
        int n;
        host_model_i.send({servo_query_pkg::CH_BANG, c, p, servo_query_pkg::CH_CR});
        for (n = 0; n < 600 && !host_model_i.done; n++) @(posedge pclk);
        chk("reply end", host_model_i.done, 1'b1);
        chk($sformatf("reply %h", c), host_model_i.reply, exp);
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Hang guard, far beyond the whole sequence
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; ctl = '0; slow = 1'b0;
        ctl.state = servo_query_pkg::CS_RUN;
        ctl.in_pos = 4'h1;
        ctl.glob_err = 16'h1234;
        for (int m = 0; m < 4; m++) motor[m] = '0;
        // Drive B distinct from A so a wrong selection shows
        motor[1] = '{9'h1FF, 16'h0600, 16'h0100, 16'h8200, 16'hFFFB, 16'h6000};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, servo_query_pkg::ADDR_MASK, 32'h0); chk("mask", rd, 32'h0);
        apb(1'b0, servo_query_pkg::ADDR_CTRL, 32'h0); chk("ctrl", rd, 32'h1);
        apb(1'b0, 8'h20, 32'h0); chk("unmapped", {err, rd}, 64'h100000000);
        query(servo_query_pkg::CMD_MOTOR_WARN, "B", "#334");
        query(servo_query_pkg::CMD_MAX_ACCEL, "B", "#1536");
        query(servo_query_pkg::CMD_MAX_CURR, "B", "#256");
        query(servo_query_pkg::CMD_DEMAND_POS, "B", "#-32256");
        query(servo_query_pkg::CMD_ACTUAL_POS, "B", "#-5");
        query(servo_query_pkg::CMD_MAX_SPEED, "B", "#24576");
        query(servo_query_pkg::CMD_FLAGS, "1", "#129");
        ctl <= '{servo_query_pkg::CS_INIT, 1'b1, 1'b1, 1'b0, 4'h0, 8'h00, 16'h1234,
                 1'b0, 4'h0};
        query(servo_query_pkg::CMD_FLAGS, "1", "#3136");
        query(servo_query_pkg::CMD_GLOB_ERR, "1", "#4660");
        ctl.state <= servo_query_pkg::CS_RUN;
        slow <= 1'b1;
        query(servo_query_pkg::CMD_STATE_LET, "1", "#R");
        slow <= 1'b0;
        query(16'h5A5A, "A", "#?");
        apb(1'b0, servo_query_pkg::ADDR_IRQ, 32'h0); chk("irq bad", rd[2:0], 3'h3);
        // Warning held past the shortened hold time must trip the error state
        ctl.ctrl_warn <= 1'b1;
        ctl.link_voltage <= 4'hA;
        query(servo_query_pkg::CMD_GLOB_WARN, "1", "#52");
        repeat (30) @(posedge pclk);
        apb(1'b0, servo_query_pkg::ADDR_STAT, 32'h0); chk("stat", rd[2:1], 2'h3);
        query(servo_query_pkg::CMD_STATE_LET, "1", "#E32");
        chk("irq masked", irq, 1'b0);
        apb(1'b1, servo_query_pkg::ADDR_MASK, 32'h4);
        @(posedge pclk);
        chk("irq on", irq, 1'b1);
        ctl.ctrl_warn <= 1'b0;
        apb(1'b1, servo_query_pkg::ADDR_CTRL, 32'h3);
        apb(1'b1, servo_query_pkg::ADDR_IRQ, 32'h7);
        @(posedge pclk);
        chk("irq off", irq, 1'b0);
        query(servo_query_pkg::CMD_STATE_LET, "1", "#R");
        apb(1'b0, servo_query_pkg::ADDR_CNT, 32'h0); chk("count", rd, 32'hE);
        print_verdict();
    end
endmodule
